// File: src/dual_timer.sv
// two 8-bit timer/event/divider counters with an ahb-lite register slave
// What this block does
// - timer mode counts internal ticks, on match raises irq, clears, continues
// - event mode counts pin falling edges, match raises irq and clears
// - divider mode toggles flip-flop, clears, raises irq on each match
// - divider output pin always drives inverse of the flip-flop
// - flip-flop loads the written control bit only while the counter is already stopped, reset clears it
// - stopped divider keeps its pin level until the control bit is rewritten
// - clearing bit 7 while stopped drives pin high; clearing bit 3 stops
// - compare value is not buffered, a write takes effect at once
// - counters cascade to 16 bits, lower clock select drives the pair
// - mode code 000 is timer/event, 001 is divider output
`timescale 1ns/1ps
`include "dual_timer_defines.svh"
module dual_timer (
	// clock and reset
	input  wire logic         I_MCLK,
	input  wire logic         I_RST_N,
	// ahb-lite slave
	input  wire logic         I_HSEL,
	input  wire logic [7:0]   I_HADDR,
	input  wire logic [1:0]   I_HTRANS,
	input  wire logic         I_HWRITE,
	input  wire logic [2:0]   I_HSIZE,
	input  wire logic [31:0]  I_HWDATA,
	input  wire logic         I_HREADY,
	output logic [31:0]       O_HRDATA,
	output logic              O_HREADYOUT,
	output logic              O_HRESP,
	// count input pins
	input  wire logic [1:0]   I_COUNT_INPUT_PIN,
	// divider outputs and interrupt
	output logic [1:0]        O_DIVIDER_OUT_PIN,
	output logic              O_IRQ
);
	import dual_timer_pkg::*;

	// ==========================================================
	// state
	typedef struct packed {
		logic [1:0][7:0] ctrl;
		logic [1:0][7:0] cmp;
		logic [1:0][7:0] cnt;
		logic [1:0]      ff;
		logic [1:0]      irq_st;
		logic [1:0]      irq_mask;
		logic            slow;
		logic [1:0]      pin_s1;
		logic [1:0]      pin_s2;
		logic [1:0]      pin_s3;
		logic            ph_wr;
		logic            ph_rd;
		logic [7:0]      ph_addr;
		logic [31:0]     rdata;
		logic [1:0]      pin_out;
		logic            irq;
	} state_t;
	state_t st_reg;
	state_t st_next;

	logic [6:0] tick;
	logic [1:0] src_tick;
	logic [1:0] match;
	logic [1:0] fall;
	logic       addr_ok;
	logic [15:0] cnt16;
	logic [15:0] cmp16;
	logic       casc;

	tick_divider #(.W(12)) u_div (
		.i_clk   (I_MCLK),
		.i_rst_n (I_RST_N),
		.o_tick  (tick)
	);

	// ==========================================================
	// tick selection
	function automatic logic pick(input clksel_t sel, input logic is_slow,
			input logic [6:0] tk, input logic fl, input mode_t md);
		logic r;
		r = 1'b0;
		if (sel == `CLKSEL_PIN) begin
			r = fl;
		end else if (is_slow) begin
			// only slow tick in slow modes
			r = (sel == `CLKSEL_SLOW8) ? tk[4] : 1'b0;
		end else if (sel == `CLKSEL_SLOW8) begin
			r = tk[0];
		end else begin
			r = tk[sel];
		end
		if (md == `MODE_TIMER_EVT && is_slow && sel != `CLKSEL_PIN
				&& sel != `CLKSEL_SLOW8) begin
			r = 1'b0;
		end
		return r;
	endfunction : pick

	always_comb begin
		casc = st_reg.ctrl[1][`CTRL_MODE_LSB+2];
		fall = st_reg.pin_s3 & ~st_reg.pin_s2;
		cnt16 = {st_reg.cnt[1], st_reg.cnt[0]};
		cmp16 = {st_reg.cmp[1], st_reg.cmp[0]};
		for (int k = 0; k < 2; k++) begin
			src_tick[k] = st_reg.ctrl[k][`CTRL_RUN_BIT] &
				pick(st_reg.ctrl[k][`CTRL_CLK_LSB +: 3], st_reg.slow, tick,
				fall[k], st_reg.ctrl[k][2:0]);
		end
		// cascade: lower select drives the pair, start from upper
		if (casc) begin
			src_tick[0] = st_reg.ctrl[1][`CTRL_RUN_BIT] &
				pick(st_reg.ctrl[0][`CTRL_CLK_LSB +: 3], st_reg.slow, tick,
				fall[0], `MODE_TIMER_EVT);
			src_tick[1] = 1'b0;
			// tick that brings the count onto the compare value
			match = {src_tick[0] && (16'(cnt16 + 16'h0001) == cmp16), 1'b0};
		end else begin
			match[0] = src_tick[0] &&
				(8'(st_reg.cnt[0] + 8'h01) == st_reg.cmp[0]);
			match[1] = src_tick[1] &&
				(8'(st_reg.cnt[1] + 8'h01) == st_reg.cmp[1]);
		end
	end

	assign addr_ok = (st_reg.ph_addr <= `OFF_SYS_MODE) &&
		(st_reg.ph_addr[1:0] == 2'b00);

	// ==========================================================
	// next state
	always_comb begin
		st_next = st_reg;
		// two-stage sync then edge stage
		st_next.pin_s1 = I_COUNT_INPUT_PIN;
		st_next.pin_s2 = st_reg.pin_s1;
		st_next.pin_s3 = st_reg.pin_s2;
		for (int k = 0; k < 2; k++) begin
			if (!st_reg.ctrl[k][`CTRL_RUN_BIT] && !(casc && k == 0)) begin
				st_next.cnt[k] = 8'h00;          // stop clears
			end
		end
		if (casc) begin
			if (!st_reg.ctrl[1][`CTRL_RUN_BIT]) begin
				st_next.cnt[0] = 8'h00;
			end else if (match[1]) begin
				{st_next.cnt[1], st_next.cnt[0]} = 16'h0000;
			end else if (src_tick[0]) begin
				{st_next.cnt[1], st_next.cnt[0]} = cnt16 + 16'h0001;
			end
			if (match[1]) begin
				st_next.irq_st[1] = 1'b1;
			end
		end else begin
			for (int k = 0; k < 2; k++) begin
				if (match[k]) begin
					st_next.cnt[k] = 8'h00;
					st_next.irq_st[k] = 1'b1;
					if (st_reg.ctrl[k][2:0] == `MODE_DIVIDER) begin
						st_next.ff[k] = ~st_reg.ff[k];
					end
				end else if (src_tick[k]) begin
					st_next.cnt[k] = st_reg.cnt[k] + 8'h01;
				end
			end
		end
		// ahb address phase
		st_next.ph_wr = 1'b0;
		st_next.ph_rd = 1'b0;
		if (I_HSEL && I_HREADY && I_HTRANS[1]) begin
			st_next.ph_wr = I_HWRITE;
			st_next.ph_rd = !I_HWRITE;
			st_next.ph_addr = I_HADDR;
		end
		// ahb data phase write
		if (st_reg.ph_wr && addr_ok) begin
			unique case (st_reg.ph_addr)
				`OFF_CTRL0, `OFF_CTRL1: begin
					st_next.ctrl[st_reg.ph_addr[3]] = I_HWDATA[7:0];
					// flip-flop loads only while already stopped
					if (!st_reg.ctrl[st_reg.ph_addr[3]][`CTRL_RUN_BIT]) begin
						st_next.ff[st_reg.ph_addr[3]] = I_HWDATA[`CTRL_FF_BIT];
					end
				end
				`OFF_CMP0, `OFF_CMP1: begin
					st_next.cmp[st_reg.ph_addr[3]] = I_HWDATA[7:0];
				end
				`OFF_IRQ_STATUS: begin
					// set wins over clear
					st_next.irq_st = st_next.irq_st &
						~(I_HWDATA[1:0] & ~(match | {match[1], 1'b0}));
				end
				`OFF_IRQ_MASK: begin
					st_next.irq_mask = I_HWDATA[1:0];
				end
				`OFF_SYS_MODE: begin
					st_next.slow = I_HWDATA[0];
				end
				default: begin
				end
			endcase
		end
		// read data registered for the address phase
		st_next.rdata = 32'h0000_0000;
		if (I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE) begin
			unique case (I_HADDR)
				`OFF_CTRL0:      st_next.rdata[7:0] = st_reg.ctrl[0];
				`OFF_CMP0:       st_next.rdata[7:0] = st_reg.cmp[0];
				`OFF_CTRL1:      st_next.rdata[7:0] = st_reg.ctrl[1];
				`OFF_CMP1:       st_next.rdata[7:0] = st_reg.cmp[1];
				`OFF_IRQ_STATUS: st_next.rdata[1:0] = st_reg.irq_st;
				`OFF_IRQ_MASK:   st_next.rdata[1:0] = st_reg.irq_mask;
				`OFF_COUNT:      st_next.rdata[15:0] = cnt16;
				`OFF_SYS_MODE:   st_next.rdata[0] = st_reg.slow;
				default:         st_next.rdata = 32'h0000_0000;
			endcase
		end
		// pin is inverse of flip-flop, holds while stopped
		st_next.pin_out = ~st_next.ff;
		st_next.irq = |(st_next.irq_st & st_next.irq_mask);
	end

	// ==========================================================
	// registers
	always_ff @(posedge I_MCLK) begin
		if (!I_RST_N) begin
			st_reg <= '0;
			st_reg.pin_out <= 2'b11;
		end else begin
			st_reg <= st_next;
		end
	end

	assign O_HRDATA = st_reg.rdata;
	assign O_HREADYOUT = 1'b1;
	assign O_HRESP = 1'b0;
	assign O_DIVIDER_OUT_PIN = st_reg.pin_out;
	assign O_IRQ = st_reg.irq;

	// ==========================================================
	// checks
	a_pin_inverse: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
		O_DIVIDER_OUT_PIN == ~st_reg.ff)
		else $error("divider pin not inverse of flip-flop");
	a_match_clear: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
		match[0] && !casc |=> st_reg.cnt[0] == 8'h00 && st_reg.irq_st[0])
		else $error("match did not clear counter or set status");
	a_div_toggle: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
		match[1] && !casc && st_reg.ctrl[1][2:0] == `MODE_DIVIDER &&
		!st_reg.ph_wr |=> st_reg.ff[1] != $past(st_reg.ff[1]))
		else $error("divider flip-flop did not toggle");
	a_stop_hold: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
		!st_reg.ctrl[0][`CTRL_RUN_BIT] && !st_reg.ph_wr |=>
		$stable(O_DIVIDER_OUT_PIN[0]))
		else $error("stopped pin changed level");
	a_event_count: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
		!casc && st_reg.ctrl[0][`CTRL_RUN_BIT] && st_reg.ctrl[0][6:4] ==
		`CLKSEL_PIN && !fall[0] |=> $stable(st_reg.cnt[0]))
		else $error("event counter moved without an edge");
	a_stop_clear: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
		!st_reg.ctrl[1][`CTRL_RUN_BIT] ##1 !st_reg.ctrl[1][`CTRL_RUN_BIT]
		|-> st_reg.cnt[1] == 8'h00)
		else $error("stopped counter not cleared");
	a_slow_gate: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
		st_reg.slow && st_reg.ctrl[1][6:4] == 3'h1 && !casc
		|-> !src_tick[1])
		else $error("fast tick used in slow mode");
	a_irq_level: assert property (@(posedge I_MCLK) disable iff (!I_RST_N)
		O_IRQ == |(st_reg.irq_st & st_reg.irq_mask))
		else $error("interrupt output mismatch");
endmodule : dual_timer

// File: src/dual_timer_defines.svh
// offsets, fields, reset values, clock selects and mode codes of the dual timer
`ifndef DUAL_TIMER_DEFINES_SVH
`define DUAL_TIMER_DEFINES_SVH
`define OFF_CTRL0        8'h00
`define OFF_CMP0         8'h04
`define OFF_CTRL1        8'h08
`define OFF_CMP1         8'h0C
`define OFF_IRQ_STATUS   8'h10
`define OFF_IRQ_MASK     8'h14
`define OFF_COUNT        8'h18
`define OFF_SYS_MODE     8'h1C
`define CTRL_MODE_LSB    0
`define CTRL_RUN_BIT     3
`define CTRL_CLK_LSB     4
`define CTRL_FF_BIT      7
`define CTRL_RESET       8'h00
`define CMP_RESET        8'h00
`define CLKSEL_SLOW8     3'h0
`define CLKSEL_PIN       3'h7
`define MODE_TIMER_EVT   3'h0
`define MODE_DIVIDER     3'h1
`define MODE_CASCADE     3'h4
`endif

// File: src/dual_timer_pkg.sv
// types shared by the dual timer files
package dual_timer_pkg;
	typedef logic [2:0] mode_t;
	typedef logic [2:0] clksel_t;
endpackage : dual_timer_pkg

// File: src/tick_divider.sv
// free-running prescaler that gives one-cycle ticks for each internal clock select
`timescale 1ns/1ps
module tick_divider #(
	parameter int W = 12
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	// tick outputs, one per internal select
	output logic [6:0]        o_tick
);
	import dual_timer_pkg::*;

	typedef struct packed {
		logic [W-1:0] cnt;
		logic [6:0]   tick;
	} state_t;
	state_t st_reg;
	state_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.cnt = st_reg.cnt + 1'b1;
		// 0:/2^11 1:/2^7 2:/2^5 3:/2^3 4:/2^8 (slow stand-in) 5:/2 6:/1
		st_next.tick[0] = &st_reg.cnt[10:0];
		st_next.tick[1] = &st_reg.cnt[6:0];
		st_next.tick[2] = &st_reg.cnt[4:0];
		st_next.tick[3] = &st_reg.cnt[2:0];
		st_next.tick[4] = &st_reg.cnt[7:0];
		st_next.tick[5] = st_reg.cnt[0];
		st_next.tick[6] = 1'b1;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_tick = st_reg.tick;
endmodule : tick_divider

// File: dv/dual_timer_test.sv
// self-checking bench for the dual timer
`timescale 1ns/1ps
`include "dual_timer_defines.svh"
module dual_timer_test;
	// ==========================================
	// signals
	logic        mclk;
	logic        rst_n;
	logic        hsel;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	wire         hready;
	logic [31:0] hrdata;
	logic        hresp;
	logic [1:0]  cnt_pin;
	logic [1:0]  div_pin;
	logic        irq;
	logic [31:0] q;
	logic [7:0]  m;
	int          n_fail;
	int          compares;
	int          n;
	int          n2;
	int          n3;

	// ==========================================
	// design
	dual_timer dut_u (
		.I_MCLK            (mclk),
		.I_RST_N           (rst_n),
		.I_HSEL            (hsel),
		.I_HADDR           (haddr),
		.I_HTRANS          (htrans),
		.I_HWRITE          (hwrite),
		.I_HSIZE           (hsize),
		.I_HWDATA          (hwdata),
		.I_HREADY          (hready),
		.O_HRDATA          (hrdata),
		.O_HREADYOUT       (hready),
		.O_HRESP           (hresp),
		.I_COUNT_INPUT_PIN (cnt_pin),
		.O_DIVIDER_OUT_PIN (div_pin),
		.O_IRQ             (irq)
	);

	always #2.5 mclk = ~mclk;

	// ==========================================
	// tasks
	task automatic chk(input string name, input logic [31:0] seen,
			input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= a;
		hwrite <= w;
		hsize  <= 3'h2;
		do @(posedge mclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
		q = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0000_0000);
	endtask : rd

	// cycles until irq (k 2) or a divider pin reaches v
	task automatic wait_until(input int k, input logic v, output int c);
		c = 0;
		while (((k == 2) ? irq : div_pin[k]) !== v && c < 2000) begin
			@(posedge mclk);
			c++;
		end
	endtask : wait_until

	// one falling edge with random hold times of four cycles or more
	task automatic fall();
		cnt_pin[0] <= 1'b0;
		repeat (4 + $urandom_range(3)) @(posedge mclk);
		cnt_pin[0] <= 1'b1;
		repeat (4 + $urandom_range(3)) @(posedge mclk);
	endtask : fall

	task automatic results();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	// ==========================================
	// watchdog
	initial begin
		repeat (60000) @(posedge mclk);
		n_fail++;
		results();
	end

	// ==========================================
	// main sequence
	initial begin
		mclk = 1'b0;
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		cnt_pin = 2'b11;
		n_fail = 0;
		compares = 0;
		q = $urandom(32'h270c);
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		// reset state, unmapped 0x20 included
		chk("reset pins", {30'h0, div_pin}, 32'h0000_0003);
		chk("reset irq", {31'h0, irq}, 32'h0000_0000);
		for (int a = 0; a < 36; a += 4) begin
			rd(8'(a));
			chk("reset read", q, 32'h0000_0000);
		end
		// timer mode, compare 1 then random
		for (int i = 0; i < 2; i++) begin
			m = (i == 0) ? 8'h01 : 8'($urandom_range(255, 2));
			wr(`OFF_CMP0, {24'h0, m});
			wr(`OFF_IRQ_MASK, 32'h0000_0001);
			wr(`OFF_CTRL0, 32'h0000_0068);
			wait_until(2, 1'b1, n);
			chk("timer irq", {31'h0, irq}, 32'h0000_0001);
			rd(`OFF_COUNT);
			chk("count range", {31'h0, q[7:0] <= m}, 32'h0000_0001);
			chk("timer pin", {31'h0, div_pin[0]}, 32'h0000_0001);
			wr(`OFF_IRQ_STATUS, 32'h0000_0001);
			wait_until(2, 1'b0, n);
			wait_until(2, 1'b1, n);
			chk("timer again", {31'h0, irq}, 32'h0000_0001);
			wr(`OFF_CTRL0, 32'h0000_0000);
			repeat (4) @(posedge mclk);
			rd(`OFF_COUNT);
			chk("stopped count", {24'h0, q[7:0]}, 32'h0000_0000);
		end
		// masking and clearing
		wr(`OFF_IRQ_MASK, 32'h0000_0000);
		repeat (2) @(posedge mclk);
		chk("masked irq", {31'h0, irq}, 32'h0000_0000);
		wr(`OFF_IRQ_MASK, 32'h0000_0001);
		repeat (2) @(posedge mclk);
		chk("unmasked irq", {31'h0, irq}, 32'h0000_0001);
		wr(`OFF_IRQ_STATUS, 32'h0000_0003);
		repeat (2) @(posedge mclk);
		chk("cleared irq", {31'h0, irq}, 32'h0000_0000);
		// event counter on pin 0
		m = 8'($urandom_range(8, 2));
		wr(`OFF_CMP0, {24'h0, m});
		wr(`OFF_CTRL0, 32'h0000_0078);
		repeat (m - 1) fall();
		rd(`OFF_IRQ_STATUS);
		chk("early match", {31'h0, q[0]}, 32'h0000_0000);
		rd(`OFF_COUNT);
		chk("event count", {24'h0, q[7:0]}, {24'h0, m - 8'h01});
		fall();
		rd(`OFF_IRQ_STATUS);
		chk("event match", {31'h0, q[0]}, 32'h0000_0001);
		rd(`OFF_COUNT);
		chk("event clear", {24'h0, q[7:0]}, 32'h0000_0000);
		wr(`OFF_CTRL0, 32'h0000_0000);
		// cascaded pair, lower select, combined compare
		m = 8'($urandom_range(40, 2));
		wr(`OFF_CMP0, {24'h0, m});
		wr(`OFF_CMP1, 32'h0000_0000);
		wr(`OFF_CTRL0, 32'h0000_0060);
		wr(`OFF_IRQ_MASK, 32'h0000_0002);
		wr(`OFF_IRQ_STATUS, 32'h0000_0003);
		wr(`OFF_CTRL1, 32'h0000_000C);
		wait_until(2, 1'b1, n);
		chk("cascade irq", {31'h0, irq}, 32'h0000_0001);
		wr(`OFF_CTRL1, 32'h0000_0000);
		wr(`OFF_CTRL0, 32'h0000_0000);
		// divider output on counter 1
		m = 8'($urandom_range(30, 4));
		wr(`OFF_CMP1, {24'h0, m});
		wr(`OFF_IRQ_MASK, 32'h0000_0002);
		wr(`OFF_IRQ_STATUS, 32'h0000_0003);
		wr(`OFF_CTRL1, 32'h0000_0069);
		wait_until(1, 1'b0, n);
		wait_until(1, 1'b1, n2);
		wait_until(1, 1'b0, n3);
		chk("half periods", 32'(n2), 32'(n3));
		chk("divider irq", {31'h0, irq}, 32'h0000_0001);
		chk("other pin", {31'h0, div_pin[0]}, 32'h0000_0001);
		// stop while low, pin holds
		wr(`OFF_CTRL1, 32'h0000_0061);
		repeat (3 * m) @(posedge mclk);
		chk("held pin", {31'h0, div_pin[1]}, 32'h0000_0000);
		wr(`OFF_CTRL1, 32'h0000_0001);
		repeat (2) @(posedge mclk);
		chk("cleared ff", {31'h0, div_pin[1]}, 32'h0000_0001);
		wr(`OFF_CTRL1, 32'h0000_0081);
		repeat (2) @(posedge mclk);
		chk("loaded ff", {31'h0, div_pin[1]}, 32'h0000_0000);
		results();
	end
endmodule : dual_timer_test
